// [hpc_port.sv]
// host port: eight external registers over an 8-bit parallel bus
// and a serial control request port, indirect channel access.
// assumes pins arrive asynchronously; channel logic answers
// int_req_o with a one-cycle int_ack_i.
`timescale 1ns/1ps
`include "hpc_port_cfg.svh"
// What this block does
// - 8-bit data, 3-bit select, strobes, status
// - two bus protocols: split strobes or data strobe
// - serial path shares identical register map
// - auto-increment channel address after low data byte access
// - non-broadcast: instruction must match chip identity
// - broadcast 0000/0001/0010 select channel groups
// - broadcast 0100/1000/1001 select chips
// - broadcast 11xx matches two identity bits
// - chip-select codes take channel from upper bits
// - upper bits pick channel, ignored if multi
// - broadcast: reads invalid, address hidden
// - address is upper bits plus address byte
// - soft-sync bits 0-3 pulse four sync lines
// - soft-sync bit 4 starts channels
// - soft-sync bit 5 updates tuning oscillator
// - soft-sync bit 6 selects test signals
// - soft-sync bit 7 picks pseudo-random or full-scale
// - data bytes carry bits 7:0, 15:8, 19:16
// - low data byte triggers the internal transfer
// - mode input selects the bus protocol
// - acknowledge low from start until completion
// - sleep bits 3-0 put channels asleep
module hpc_port
  import hpc_port_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic mode_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic access_acknowledge_n_o,
  input wire logic [3:0] chip_identity_pins_i,
  input wire logic ser_req_i,
  input wire logic ser_wr_i,
  input wire logic [2:0] ser_addr_i,
  input wire logic [7:0] ser_wdata_i,
  output logic [7:0] ser_rdata_o,
  output logic ser_done_o,
  output logic int_req_o,
  output logic int_wr_o,
  output logic [9:0] int_addr_o,
  output logic [19:0] int_wdata_o,
  output logic [3:0] int_chan_sel_o,
  input wire logic [19:0] int_rdata_i,
  input wire logic int_ack_i,
  output logic [3:0] sleep_o,
  output logic serial_read_o,
  output logic input_port_access_o,
  output logic [7:0] pin_sync_ctrl_o,
  output logic [3:0] soft_sync_o,
  output logic start_o,
  output logic hop_o,
  output logic test_source_enable_o,
  output logic prbs_source_select_o
);

  // ============================================================
  // pin synchroniser: three stages, change taken when 2nd/3rd agree
  logic [`HPC_PIN_W-1:0] pin_raw, pin_s1_q, pin_s2_q, pin_s3_q;
  logic [`HPC_PIN_W-1:0] pin_f_q, pin_f_d;
  logic f_mode, f_cs_n, f_rd_n, f_wr_n;
  logic [2:0] f_addr;
  logic [7:0] f_data;
  logic [3:0] f_chip_identity_pins;

  assign pin_raw = {mode_i, cs_n_i, rd_n_i, wr_n_i, addr_i, data_i,
    chip_identity_pins_i};
  assign pin_f_d = (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));
  assign {f_mode, f_cs_n, f_rd_n, f_wr_n, f_addr, f_data, f_chip_identity_pins} =
    pin_f_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= `HPC_PIN_RST;
      pin_s2_q <= `HPC_PIN_RST;
      pin_s3_q <= `HPC_PIN_RST;
      pin_f_q <= `HPC_PIN_RST;
    end else if (clk_en_i) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d;
    end
  end

  // ============================================================
  // strobe decode for both protocols
  logic par_rd, par_wr, par_active;

  assign par_rd = f_mode ? (!f_rd_n && f_wr_n) : !f_rd_n;
  assign par_wr = f_mode ? (!f_rd_n && !f_wr_n) : !f_wr_n;
  assign par_active = !f_cs_n && (par_rd || par_wr);

  // ============================================================
  // state and registers
  hpc_state_t state_q, state_d;
  hpc_src_t src_q, src_d;
  logic wr_q, wr_d, need_int_q, need_int_d, drive_q, drive_d;
  logic ser_done_q, ser_done_d;
  logic [2:0] addr_q, addr_d;
  logic [3:0] chan_q, chan_d, pulse_q, pulse_d, dtop_q, dtop_d;
  logic start_q, start_d, hop_q, hop_d;
  logic [7:0] acr_q, acr_d, car_q, car_d, dlo_q, dlo_d, dmid_q, dmid_d;
  logic [7:0] sleep_q, sleep_d, pin_q, pin_d, soft_q, soft_d;
  logic [7:0] rdata_q, rdata_d;

  // ============================================================
  // channel decoder
  hpc_dec_if dec_bus();

  assign dec_bus.bcast = acr_q[`HPC_ACR_BCAST];
  assign dec_bus.instr = acr_q[`HPC_ACR_INSTR_HI:`HPC_ACR_INSTR_LO];
  assign dec_bus.upper = acr_q[`HPC_ACR_UPPER_HI:0];
  assign dec_bus.chip_identity_pins = f_chip_identity_pins;

  hpc_chan_decode u_dec (
    .bus(dec_bus)
  );

  // ============================================================
  // access taken from either path, parallel first
  logic par_take, ser_take, take_any, take_wr, bcast;
  logic [2:0] take_addr;
  logic [7:0] take_wdata;

  assign bcast = acr_q[`HPC_ACR_BCAST];
  assign par_take = (state_q == HPC_ST_IDLE) && par_active;
  assign ser_take = (state_q == HPC_ST_IDLE) && !par_active &&
    ser_req_i && !ser_done_q;
  assign take_any = par_take || ser_take;
  assign take_wr = par_take ? par_wr : ser_wr_i;
  assign take_addr = par_take ? f_addr : ser_addr_i;
  assign take_wdata = par_take ? f_data : ser_wdata_i;

  // ============================================================
  // next-value logic for the sequencer and registers
  always_comb begin
    state_d = state_q;
    src_d = src_q;
    wr_d = wr_q;
    addr_d = addr_q;
    need_int_d = need_int_q;
    drive_d = drive_q;
    chan_d = chan_q;
    acr_d = acr_q;
    car_d = car_q;
    dlo_d = dlo_q;
    dmid_d = dmid_q;
    dtop_d = dtop_q;
    sleep_d = sleep_q;
    pin_d = pin_q;
    soft_d = soft_q;
    rdata_d = rdata_q;
    pulse_d = 4'h0;
    start_d = 1'b0;
    hop_d = 1'b0;
    ser_done_d = 1'b0;
    case (state_q)
      HPC_ST_IDLE: begin
        if (take_any) begin
          state_d = HPC_ST_BUSY;
          src_d = par_take ? HPC_SRC_PAR : HPC_SRC_SER;
          wr_d = take_wr;
          addr_d = take_addr;
          chan_d = dec_bus.chan_sel;
          drive_d = !take_wr && !bcast &&
            (dec_bus.chan_sel != `HPC_CHAN_NONE);
          need_int_d = (take_addr == `HPC_OFS_DATA_LOW) &&
            (take_wr || !bcast) &&
            (dec_bus.chan_sel != `HPC_CHAN_NONE);
          if (take_wr) begin
            case (take_addr)
              `HPC_OFS_DATA_LOW: dlo_d = take_wdata;
              `HPC_OFS_DATA_MID: dmid_d = take_wdata;
              `HPC_OFS_DATA_TOP: dtop_d = take_wdata[3:0];
              `HPC_OFS_SLEEP_CTRL: sleep_d = take_wdata;
              `HPC_OFS_PIN_SYNC: pin_d = take_wdata;
              `HPC_OFS_SOFT_SYNC: begin
                soft_d = take_wdata;
                pulse_d = take_wdata[3:0];
                start_d = take_wdata[`HPC_SS_START];
                hop_d = take_wdata[`HPC_SS_HOP];
              end
              `HPC_OFS_CHAN_ADDR: car_d = take_wdata;
              `HPC_OFS_ACCESS_CTRL: acr_d = take_wdata;
              default: acr_d = acr_q;
            endcase
          end else begin
            case (take_addr)
              `HPC_OFS_DATA_LOW: begin
                rdata_d = bcast ? `HPC_REG_RST : dlo_q;
                if (bcast) begin
                  dlo_d = `HPC_REG_RST;
                  dmid_d = `HPC_REG_RST;
                  dtop_d = `HPC_NIB_RST;
                end
              end
              `HPC_OFS_DATA_MID: rdata_d = dmid_q;
              `HPC_OFS_DATA_TOP: rdata_d = {4'h0, dtop_q};
              `HPC_OFS_CHAN_ADDR: begin
                rdata_d = bcast ? `HPC_REG_RST : car_q;
              end
              `HPC_OFS_ACCESS_CTRL: rdata_d = acr_q;
              default: rdata_d = `HPC_REG_RST;
            endcase
          end
        end
      end
      HPC_ST_BUSY: begin
        if (!need_int_q || int_ack_i) begin
          if (need_int_q && !wr_q) begin
            dlo_d = int_rdata_i[7:0];
            dmid_d = int_rdata_i[15:8];
            dtop_d = int_rdata_i[19:16];
            rdata_d = int_rdata_i[7:0];
          end
          if (addr_q == `HPC_OFS_DATA_LOW &&
              acr_q[`HPC_ACR_AUTOINC]) begin
            car_d = car_q + 8'h01;
          end
          if (src_q == HPC_SRC_SER) begin
            state_d = HPC_ST_IDLE;
            ser_done_d = 1'b1;
          end else begin
            state_d = HPC_ST_DONE;
          end
        end
      end
      HPC_ST_DONE: begin
        if (!par_active) begin
          state_d = HPC_ST_IDLE;
        end
      end
      default: state_d = HPC_ST_IDLE;
    endcase
  end

  // ============================================================
  // register stage, reset loads the idle state and zeroes the rest
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= HPC_ST_IDLE;
      src_q <= HPC_SRC_PAR;
      wr_q <= 1'b0;
      addr_q <= 3'h0;
      need_int_q <= 1'b0;
      drive_q <= 1'b0;
      chan_q <= `HPC_CHAN_NONE;
      acr_q <= `HPC_REG_RST;
      car_q <= `HPC_REG_RST;
      dlo_q <= `HPC_REG_RST;
      dmid_q <= `HPC_REG_RST;
      dtop_q <= `HPC_NIB_RST;
      sleep_q <= `HPC_REG_RST;
      pin_q <= `HPC_REG_RST;
      soft_q <= `HPC_REG_RST;
      rdata_q <= `HPC_REG_RST;
      pulse_q <= 4'h0;
      start_q <= 1'b0;
      hop_q <= 1'b0;
      ser_done_q <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      src_q <= src_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      need_int_q <= need_int_d;
      drive_q <= drive_d;
      chan_q <= chan_d;
      acr_q <= acr_d;
      car_q <= car_d;
      dlo_q <= dlo_d;
      dmid_q <= dmid_d;
      dtop_q <= dtop_d;
      sleep_q <= sleep_d;
      pin_q <= pin_d;
      soft_q <= soft_d;
      rdata_q <= rdata_d;
      pulse_q <= pulse_d;
      start_q <= start_d;
      hop_q <= hop_d;
      ser_done_q <= ser_done_d;
    end
  end

  // ============================================================
  // outputs
  assign access_acknowledge_n_o = (state_q != HPC_ST_BUSY);
  assign data_o = rdata_q;
  assign data_oe_o = drive_q && par_active && par_rd &&
    (state_q == HPC_ST_DONE);
  assign ser_rdata_o = rdata_q;
  assign ser_done_o = ser_done_q;
  assign int_req_o = (state_q == HPC_ST_BUSY) && need_int_q;
  assign int_wr_o = wr_q;
  assign int_addr_o = {acr_q[`HPC_ACR_UPPER_HI:0], car_q};
  assign int_wdata_o = {dtop_q, dmid_q, dlo_q};
  assign int_chan_sel_o = chan_q;
  assign sleep_o = sleep_q[3:0];
  assign serial_read_o = sleep_q[`HPC_SLP_SER_READ];
  assign input_port_access_o = sleep_q[`HPC_SLP_INPUT_PORT];
  assign pin_sync_ctrl_o = pin_q;
  assign soft_sync_o = pulse_q;
  assign start_o = start_q;
  assign hop_o = hop_q;
  assign test_source_enable_o = soft_q[`HPC_SS_TEST];
  assign prbs_source_select_o = soft_q[`HPC_SS_PRBS];

  // ============================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_dr0_finish;
    clk_en_i && state_q == HPC_ST_BUSY &&
      addr_q == `HPC_OFS_DATA_LOW && (!need_int_q || int_ack_i);
  endsequence

  sequence seq_take_read(logic [2:0] a);
    clk_en_i && take_any && !take_wr && take_addr == a;
  endsequence

  chk_autoinc_step: assert property (
    seq_dr0_finish ##0 acr_q[`HPC_ACR_AUTOINC] |=>
      car_q == $past(car_q) + 8'h01)
    else $error("address did not step after data access");

  chk_autoinc_off: assert property (
    seq_dr0_finish ##0 !acr_q[`HPC_ACR_AUTOINC] |=> $stable(car_q))
    else $error("address moved with auto-increment off");

  chk_ack_start: assert property (
    clk_en_i && par_take |=> !access_acknowledge_n_o)
    else $error("acknowledge not low after access start");

  chk_ack_release: assert property (
    clk_en_i && int_req_o && int_ack_i |=> access_acknowledge_n_o)
    else $error("acknowledge not released after completion");

  chk_addr_hidden: assert property (
    seq_take_read(`HPC_OFS_CHAN_ADDR) ##0 bcast |=>
      rdata_q == 8'h00 && !drive_q)
    else $error("address readable during broadcast");

  chk_top_nibble: assert property (
    seq_take_read(`HPC_OFS_DATA_TOP) |=> rdata_q[7:4] == 4'h0)
    else $error("reserved data bits read nonzero");

  chk_soft_pulse: assert property (
    clk_en_i && take_any && take_wr &&
      take_addr == `HPC_OFS_SOFT_SYNC |=>
      soft_sync_o == $past(take_wdata[3:0]) &&
      start_o == $past(take_wdata[4]) && hop_o == $past(take_wdata[5]))
    else $error("soft sync pulses wrong");

  chk_sleep_bits: assert property (
    clk_en_i && take_any && take_wr &&
      take_addr == `HPC_OFS_SLEEP_CTRL |=>
      sleep_o == $past(take_wdata[3:0]))
    else $error("sleep outputs wrong");

  chk_bcast_all: assert property (
    bcast && dec_bus.instr == 4'h0 |-> dec_bus.chan_sel == 4'hF)
    else $error("broadcast all not decoded");

  chk_id_mismatch: assert property (
    !bcast && dec_bus.instr != f_chip_identity_pins |-> dec_bus.chan_sel == 4'h0)
    else $error("foreign chip took the access");

  chk_undef_code: assert property (
    bcast && dec_bus.instr == 4'h3 |-> dec_bus.chan_sel == 4'h0)
    else $error("undefined code selected channels");

  chk_int_grant: assert property (
    int_req_o |-> int_chan_sel_o != 4'h0 && $stable(int_addr_o))
    else $error("internal access without a channel");

endmodule

// [hpc_port_cfg.svh]
// constants for the host port: register offsets, field positions,
// reset values and broadcast instruction codes.
// assumes inclusion by bare name from the port's design files.
`ifndef HPC_PORT_CFG_SVH
`define HPC_PORT_CFG_SVH

// ============================================================
// external register select codes
`define HPC_OFS_DATA_LOW 3'h0
`define HPC_OFS_DATA_MID 3'h1
`define HPC_OFS_DATA_TOP 3'h2
`define HPC_OFS_SLEEP_CTRL 3'h3
`define HPC_OFS_PIN_SYNC 3'h4
`define HPC_OFS_SOFT_SYNC 3'h5
`define HPC_OFS_CHAN_ADDR 3'h6
`define HPC_OFS_ACCESS_CTRL 3'h7

// ============================================================
// access_control fields
`define HPC_ACR_AUTOINC 7
`define HPC_ACR_BCAST 6
`define HPC_ACR_INSTR_HI 5
`define HPC_ACR_INSTR_LO 2
`define HPC_ACR_UPPER_HI 1

// ============================================================
// software_sync_control and sleep fields
`define HPC_SS_START 4
`define HPC_SS_HOP 5
`define HPC_SS_TEST 6
`define HPC_SS_PRBS 7
`define HPC_SLP_SER_READ 4
`define HPC_SLP_INPUT_PORT 5

// ============================================================
// reset values
`define HPC_REG_RST 8'h00
`define HPC_NIB_RST 4'h0
`define HPC_PIN_W 19
`define HPC_PIN_RST 19'h38000

// ============================================================
// broadcast instruction codes and channel groups
`define HPC_INS_ALL 4'h0
`define HPC_INS_CH012 4'h1
`define HPC_INS_CH123 4'h2
`define HPC_INS_ALL_CHIPS 4'h4
`define HPC_INS_ID_EVEN 4'h8
`define HPC_INS_ID_ODD 4'h9
`define HPC_INS_ID2_PFX 2'h3
`define HPC_CHAN_NONE 4'h0
`define HPC_CHAN_ALL 4'hF
`define HPC_CHAN_012 4'h7
`define HPC_CHAN_123 4'hE
`define HPC_CHAN_ONE 4'h1

`endif

// [hpc_port_pkg.sv]
// types shared by the host port modules.
// assumes nothing of its surroundings.
package hpc_port_pkg;

  // ============================================================
  // access sequencer states
  typedef enum logic [2:0] {
    HPC_ST_IDLE = 3'b001,
    HPC_ST_BUSY = 3'b010,
    HPC_ST_DONE = 3'b100
  } hpc_state_t;

  // ============================================================
  // which path issued the access
  typedef enum logic {
    HPC_SRC_PAR = 1'b0,
    HPC_SRC_SER = 1'b1
  } hpc_src_t;

endpackage

// [hpc_dec_if.sv]
// interface between the port and its channel decoder.
// assumes the port drives the fields and reads the channel select.
`timescale 1ns/1ps
interface hpc_dec_if;
  logic bcast;
  logic [3:0] instr;
  logic [1:0] upper;
  logic [3:0] chip_identity_pins;
  logic [3:0] chan_sel;
  modport port (output bcast, output instr, output upper,
    output chip_identity_pins, input chan_sel);
  modport dec (input bcast, input instr, input upper,
    input chip_identity_pins, output chan_sel);
endinterface

// [hpc_chan_decode.sv]
// channel decoder: turns access_control and chip identity into
// a four-bit channel select.
// assumes stable inputs from the port's registers and pin filter.
`timescale 1ns/1ps
`include "hpc_port_cfg.svh"
module hpc_chan_decode
  import hpc_port_pkg::*;
(
  hpc_dec_if.dec bus
);

  logic [3:0] one_chan;

  // ============================================================
  // single channel from the two upper address bits
  assign one_chan = `HPC_CHAN_ONE << bus.upper;

  // ============================================================
  // instruction decode
  always_comb begin
    bus.chan_sel = `HPC_CHAN_NONE;
    if (!bus.bcast) begin
      if (bus.instr == bus.chip_identity_pins) begin
        bus.chan_sel = one_chan;
      end
    end else begin
      case (bus.instr)
        `HPC_INS_ALL: bus.chan_sel = `HPC_CHAN_ALL;
        `HPC_INS_CH012: bus.chan_sel = `HPC_CHAN_012;
        `HPC_INS_CH123: bus.chan_sel = `HPC_CHAN_123;
        `HPC_INS_ALL_CHIPS: bus.chan_sel = one_chan;
        `HPC_INS_ID_EVEN: begin
          if (!bus.chip_identity_pins[0]) begin
            bus.chan_sel = one_chan;
          end
        end
        `HPC_INS_ID_ODD: begin
          if (bus.chip_identity_pins[0]) begin
            bus.chan_sel = one_chan;
          end
        end
        default: begin
          if (bus.instr[3:2] == `HPC_INS_ID2_PFX &&
              bus.instr[1:0] == bus.chip_identity_pins[1:0]) begin
            bus.chan_sel = one_chan;
          end else begin
            bus.chan_sel = `HPC_CHAN_NONE;
          end
        end
      endcase
    end
  end

endmodule

// [hpc_chan_model.sv]
// channel-side model: answers internal requests of the host port.
// assumes one clock; request fields stay stable until acknowledged.
`timescale 1ns/1ps
module hpc_chan_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic int_req_i,
  input wire logic int_wr_i,
  input wire logic [9:0] int_addr_i,
  input wire logic [19:0] int_wdata_i,
  input wire logic [3:0] int_chan_sel_i,
  output logic [19:0] int_rdata_o,
  output logic int_ack_o,
  output logic last_wr_o,
  output logic [9:0] last_addr_o,
  output logic [19:0] last_wdata_o,
  output logic [3:0] last_sel_o,
  output logic [15:0] req_cnt_o
);
  // ==========================================================
  // channel storage and answer timing
  logic [19:0] mem [0:1023];
  logic [1:0] wait_q;
  logic sent_q, go;

  // answer once the stall has run out and no ack went out yet
  assign go = int_req_i && !sent_q && wait_q == 2'h0;

  // stall 0..3 cycles, then one ack pulse; read data scrambled
  // outside the ack so stale data never looks valid
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_ack_o <= 1'b0;
      sent_q <= 1'b0;
      wait_q <= 2'h0;
      req_cnt_o <= 16'h0000;
      int_rdata_o <= 20'h00000;
    end else begin
      int_ack_o <= go;
      int_rdata_o <= go ? mem[int_addr_i] : ~int_rdata_o;
      if (!int_req_i) begin
        sent_q <= 1'b0;
        wait_q <= req_cnt_o[1:0];
      end else if (!sent_q && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (go) begin
        sent_q <= 1'b1;
        if (int_wr_i) mem[int_addr_i] <= int_wdata_i;
        last_wr_o <= int_wr_i;
        last_addr_o <= int_addr_i;
        last_wdata_o <= int_wdata_i;
        last_sel_o <= int_chan_sel_i;
        req_cnt_o <= req_cnt_o + 16'h0001;
      end
    end
  end
endmodule

// [hpc_port_tb.sv]
// self-checking bench for the host port, both bus protocols.
// assumes hpc_chan_model on the internal side; clk_en held high.
`timescale 1ns/1ps
module hpc_port_tb;
  // ==========================================================
  // signals
  logic sys_clk_i, rst_n_i, mode_i, cs_n_i, rd_n_i, wr_n_i, oe;
  logic [2:0] addr_i, ser_addr_i;
  logic [7:0] data_i, data_o, ser_wdata_i, ser_rdata_o, pin_sync_ctrl_o;
  logic [3:0] chip_identity_pins_i, int_chan_sel_o, sleep_o, soft_sync_o;
  logic data_oe_o, access_acknowledge_n_o, ser_req_i, ser_wr_i, ser_done_o;
  logic int_req_o, int_wr_o, int_ack_i, serial_read_o, input_port_access_o;
  logic start_o, hop_o, test_source_enable_o, prbs_source_select_o, m_wr;
  logic [9:0] int_addr_o, m_addr;
  logic [19:0] int_wdata_o, int_rdata_i, m_wdata, w;
  logic [3:0] m_sel;
  logic [15:0] m_cnt, c0;
  logic [7:0] q, v, access_control, channel_address_low;
  logic [5:0] acc;
  int error_cnt, n_checks, seed_v, pcnt;

  hpc_port hpc_port_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(1'b1), .mode_i(mode_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
    .wr_n_i(wr_n_i), .addr_i(addr_i), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .access_acknowledge_n_o(access_acknowledge_n_o),
    .chip_identity_pins_i(chip_identity_pins_i), .ser_req_i(ser_req_i),
    .ser_wr_i(ser_wr_i), .ser_addr_i(ser_addr_i), .ser_wdata_i(ser_wdata_i),
    .ser_rdata_o(ser_rdata_o), .ser_done_o(ser_done_o),
    .int_req_o(int_req_o), .int_wr_o(int_wr_o), .int_addr_o(int_addr_o),
    .int_wdata_o(int_wdata_o), .int_chan_sel_o(int_chan_sel_o),
    .int_rdata_i(int_rdata_i), .int_ack_i(int_ack_i), .sleep_o(sleep_o),
    .serial_read_o(serial_read_o), .input_port_access_o(input_port_access_o),
    .pin_sync_ctrl_o(pin_sync_ctrl_o), .soft_sync_o(soft_sync_o),
    .start_o(start_o), .hop_o(hop_o),
    .test_source_enable_o(test_source_enable_o),
    .prbs_source_select_o(prbs_source_select_o));

  hpc_chan_model hpc_chan_model_i (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .int_req_i(int_req_o), .int_wr_i(int_wr_o),
    .int_addr_i(int_addr_o), .int_wdata_i(int_wdata_o),
    .int_chan_sel_i(int_chan_sel_o), .int_rdata_o(int_rdata_i),
    .int_ack_o(int_ack_i), .last_wr_o(m_wr), .last_addr_o(m_addr),
    .last_wdata_o(m_wdata), .last_sel_o(m_sel), .req_cnt_o(m_cnt));

  // ==========================================================
  // clock and pulse monitor
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // gather sync pulses and count cycles carrying any
  always @(negedge sys_clk_i) begin
    acc = acc | {hop_o, start_o, soft_sync_o};
    if (|{hop_o, start_o, soft_sync_o}) pcnt++;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // expected channel grant for an access_control value and chip_identity_pins
  function automatic logic [3:0] exp_sel(input logic [7:0] a,
    input logic [3:0] id);
    logic [3:0] one;
    one = 4'h1 << a[1:0];
    if (!a[6]) return (a[5:2] == id) ? one : 4'h0;
    case (a[5:2])
      4'h0: return 4'hF;
      4'h1: return 4'h7;
      4'h2: return 4'hE;
      4'h4: return one;
      4'h8: return id[0] ? 4'h0 : one;
      4'h9: return id[0] ? one : 4'h0;
      4'hC, 4'hD, 4'hE, 4'hF: return (id[1:0] == a[3:2]) ? one : 4'h0;
      default: return 4'h0;
    endcase
  endfunction

  // one parallel access; wr_n doubles as rw in data-strobe mode
  task automatic bus(input logic wr, input logic [2:0] a,
    input logic [7:0] d, output logic [7:0] rq, output logic roe);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cs_n_i <= 1'b0;
    addr_i <= a;
    data_i <= d;
    rd_n_i <= mode_i ? 1'b0 : wr;
    wr_n_i <= !wr;
    while (access_acknowledge_n_o !== 1'b0 && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk({31'h0, access_acknowledge_n_o}, 32'h0);
    while (access_acknowledge_n_o !== 1'b1 && n < 80) begin
      @(negedge sys_clk_i);
      n++;
    end
    @(negedge sys_clk_i);
    rq = data_o;
    roe = data_oe_o;
    chk({31'h0, n < 80}, 32'h1);
    @(posedge sys_clk_i);
    cs_n_i <= 1'b1;
    rd_n_i <= 1'b1;
    wr_n_i <= 1'b1;
    data_i <= ~d;
    repeat (8) @(posedge sys_clk_i);
  endtask

  // one serial control request, held until done
  task automatic ser(input logic wr, input logic [2:0] a,
    input logic [7:0] d, output logic [7:0] rq);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    ser_req_i <= 1'b1;
    ser_wr_i <= wr;
    ser_addr_i <= a;
    ser_wdata_i <= d;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (ser_done_o !== 1'b1 && n < 60);
    rq = ser_rdata_o;
    chk({31'h0, n < 60}, 32'h1);
    @(posedge sys_clk_i);
    ser_req_i <= 1'b0;
    ser_wdata_i <= ~d;
    repeat (4) @(posedge sys_clk_i);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    error_cnt++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed_v = $urandom(49);
    error_cnt = 0;
    n_checks = 0;
    acc = 6'h00;
    pcnt = 0;
    rst_n_i = 1'b0;
    {mode_i, cs_n_i, rd_n_i, wr_n_i} = 4'h7;
    {addr_i, data_i, ser_req_i, ser_wr_i, ser_addr_i, ser_wdata_i} = 0;
    chip_identity_pins_i = 4'($urandom);
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(negedge sys_clk_i);
    chk({sleep_o, serial_read_o, input_port_access_o}, 32'h0);
    chk({test_source_enable_o, prbs_source_select_o}, 32'h0);
    chk({access_acknowledge_n_o, data_oe_o, pin_sync_ctrl_o}, 32'h200);
    bus(0, 3'h7, 8'h00, q, oe);
    chk(q, 32'h0);
    bus(0, 3'h6, 8'h00, q, oe);
    chk(q, 32'h0);
    // full write then read of one word, in each protocol
    for (int m = 0; m < 2; m++) begin
      mode_i <= m[0];
      repeat (6) @(posedge sys_clk_i);
      access_control = {2'b10, chip_identity_pins_i, 2'($urandom)};
      channel_address_low = 8'($urandom);
      w = 20'($urandom);
      bus(1, 3'h7, access_control, q, oe);
      bus(1, 3'h6, channel_address_low, q, oe);
      bus(1, 3'h2, {4'($urandom), w[19:16]}, q, oe);
      bus(1, 3'h1, w[15:8], q, oe);
      bus(1, 3'h0, w[7:0], q, oe);
      chk({m_wr, m_addr, m_wdata}, {1'b1, access_control[1:0], channel_address_low, w});
      chk(m_sel, exp_sel(access_control, chip_identity_pins_i));
      bus(0, 3'h6, 8'h00, q, oe);
      chk(q, channel_address_low + 8'h01);
      bus(1, 3'h6, channel_address_low, q, oe);
      bus(0, 3'h0, 8'h00, q, oe);
      chk({oe, q, m_wr}, {1'b1, w[7:0], 1'b0});
      bus(0, 3'h1, 8'h00, q, oe);
      chk(q, w[15:8]);
      bus(0, 3'h2, 8'h00, q, oe);
      chk(q, {4'h0, w[19:16]});
      bus(0, 3'h7, 8'h00, q, oe);
      chk(q, access_control);
    end
    // identity mismatch takes no access
    bus(1, 3'h7, {2'b00, ~chip_identity_pins_i, 2'b01}, q, oe);
    c0 = m_cnt;
    bus(1, 3'h0, 8'h5A, q, oe);
    chk(m_cnt, c0);
    // every broadcast code twice, random identity
    for (int i = 0; i < 32; i++) begin
      chip_identity_pins_i <= 4'($urandom);
      access_control = {2'b01, i[3:0], 2'($urandom)};
      bus(1, 3'h7, access_control, q, oe);
      c0 = m_cnt;
      bus(1, 3'h0, 8'($urandom), q, oe);
      if (exp_sel(access_control, chip_identity_pins_i) === 4'h0) chk(m_cnt, c0);
      else chk({m_cnt, m_sel},
        {c0 + 16'h1, exp_sel(access_control, chip_identity_pins_i)});
    end
    bus(0, 3'h6, 8'h00, q, oe);
    chk({oe, q}, 32'h0);
    bus(1, 3'h7, 8'h00, q, oe);
    // write-only control registers
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      acc = 6'h00;
      pcnt = 0;
      bus(1, 3'h5, v, q, oe);
      chk(acc, v[5:0]);
      chk(pcnt, |v[5:0]);
      chk({prbs_source_select_o, test_source_enable_o}, v[7:6]);
      bus(1, 3'h3, v, q, oe);
      chk({input_port_access_o, serial_read_o, sleep_o}, v[5:0]);
      bus(1, 3'h4, v, q, oe);
      chk(pin_sync_ctrl_o, v);
    end
    bus(0, 3'h5, 8'h00, q, oe);
    chk(q, 32'h0);
    // serial path shares the map
    v = {2'b00, chip_identity_pins_i, 2'($urandom)};
    ser(1, 3'h7, v, q);
    bus(0, 3'h7, 8'h00, q, oe);
    chk(q, v);
    bus(1, 3'h6, 8'h3C, q, oe);
    ser(0, 3'h6, 8'h00, q);
    chk(q, 32'h3C);
    acc = 6'h00;
    ser(1, 3'h5, 8'h3F, q);
    chk(acc, 32'h3F);
    end_of_test();
  end
endmodule
